// ==== bench/aof_audio_out_properties.sv ====
// checker: port properties
`timescale 1ns/1ns
module aof_audio_out_chk
    import aof_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic [7:0] REG_RDATA,
    input wire logic CONTROL_OUT_ZERO_IN,
    input wire logic CONTROL_OUT_TWO_IN,
    input wire logic WS_OE,
    input wire logic SCK_O,
    input wire logic SD_O,
    input wire logic CONTROL_OUT_ZERO_PIN,
    input wire logic CONTROL_OUT_TWO_PIN
);
    logic [7:0] mode, ctl, route, pol;
    logic [1:0] cnt;
    logic q;
    // judge outputs only once writes have landed
    assign q = cnt == 2'h3;
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            {mode, ctl, route, pol, cnt} <= '0;
        else
        begin
            cnt <= REG_WE ? 2'h0 : (q ? cnt : cnt + 2'h1);
            if (REG_WE && REG_ADDR == ADDR_AUDIO_MODE) mode <= REG_WDATA;
            if (REG_WE && REG_ADDR == ADDR_MCLK_CTRL) ctl <= REG_WDATA;
            if (REG_WE && REG_ADDR == ADDR_MCLK_ROUTE) route <= REG_WDATA;
            if (REG_WE && REG_ADDR == ADDR_POLARITY) pol <= REG_WDATA;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    property p_rd_idle; !REG_RE |=> REG_RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; REG_RE && REG_ADDR == 8'h40 |=> REG_RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_readback; REG_RE && !REG_WE && REG_ADDR == ADDR_MCLK_CTRL |=> REG_RDATA == $past(ctl); endproperty
    a_readback: assert property (p_readback) else $error("divider readback wrong");
    property p_oe_mode; q |-> WS_OE == !mode[BIT_EXT_CLOCK]; endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("clock direction wrong");
    property p_ext_wr; REG_WE && REG_ADDR == ADDR_AUDIO_MODE && REG_WDATA[BIT_EXT_CLOCK] |-> ##[1:3] !WS_OE; endproperty
    a_ext_wr: assert property (p_ext_wr) else $error("clocks not released");
    property p_mclk_off; q && ctl[6:0] == 7'h00 |-> CONTROL_OUT_ZERO_PIN == $past(CONTROL_OUT_ZERO_IN); endproperty
    a_mclk_off: assert property (p_mclk_off) else $error("control pin not restored");
    property p_pin_sel; q && ctl[6:0] != 7'h00 && route[BIT_MCLK_PIN] |-> CONTROL_OUT_TWO_PIN == $past(CONTROL_OUT_TWO_IN);
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("unselected pin lost control");
    property p_sd_edge; q && !mode[BIT_EXT_CLOCK] && !pol[BIT_POL_OUT_SCK] && $changed(SD_O) |-> !SCK_O; endproperty
    a_sd_edge: assert property (p_sd_edge) else $error("data moved while clock high");
endmodule

bind aof_audio_out aof_audio_out_chk u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .WS_OE(WS_OE),
    .CONTROL_OUT_ZERO_IN(CONTROL_OUT_ZERO_IN), .CONTROL_OUT_TWO_IN(CONTROL_OUT_TWO_IN), .SCK_O(SCK_O),
    .SD_O(SD_O), .CONTROL_OUT_ZERO_PIN(CONTROL_OUT_ZERO_PIN), .CONTROL_OUT_TWO_PIN(CONTROL_OUT_TWO_PIN));

// ==== bench/aof_sink_model.sv ====
// audio sink model: samples data, can supply clocks
`timescale 1ns/1ns
module aof_sink_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ext,
    input wire logic run,
    input wire logic sck,
    input wire logic ws,
    input wire logic sd,
    output logic sck_m,
    output logic ws_m,
    output logic [15:0] cap,
    output logic [15:0] n_hi,
    output logic [15:0] n_lo
);
    logic sck_q;
    logic [3:0] ph;
    logic [1:0] nb;
    logic tg;
    // own clocks stand still unless told to run
    assign tg = run && ph == 4'hf;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            {sck_q, sck_m, ws_m, ph, nb, cap, n_hi, n_lo} <= '0;
        else
        begin
            sck_q <= sck;
            ph <= run ? ph + 4'h1 : ph;
            if (tg) sck_m <= !sck_m;
            if (tg && sck_m) nb <= nb + 2'h1;
            if (tg && sck_m && nb == 2'h3) ws_m <= !ws_m;
            if (sck && !sck_q) cap <= {cap[14:0], sd};
            if (sck && !sck_q && !ext && ws) n_hi <= n_hi + 16'h1;
            if (sck && !sck_q && !ext && !ws) n_lo <= n_lo + 16'h1;
        end
    end
endmodule

// ==== bench/test_aof_audio_out.sv ====
// testbench for the audio output block
`timescale 1ns/1ns
module test_aof_audio_out;
    import aof_pkg::*;
    localparam logic [7:0] PAT = 8'h2d;
    logic clk, arst_n, we, re, lws, lsck, lsd, bus32, osc, c0, c2, ext, run;
    logic ws_o, ws_oe, sck_o, sck_oe, sd_o, p0, p2, ws_m, sck_m, ws_p, sck_p;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] pix;
    logic [15:0] cap, n_hi, n_lo;
    int n_fail, checks_done;
    assign ws_p = ws_oe ? ws_o : ws_m;
    assign sck_p = sck_oe ? sck_o : sck_m;
    aof_audio_out u_dut (.CLK_SYS(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
        .REG_RE(re), .REG_RDATA(rdata), .LINK_WS(lws), .LINK_SCK(lsck), .LINK_SD(lsd), .BUS_WIDTH_32(bus32),
        .PIX_MULT_TICK(pix), .OSC_TICK(osc), .CONTROL_OUT_ZERO_IN(c0), .CONTROL_OUT_TWO_IN(c2), .WS_I(ws_p),
        .WS_O(ws_o), .WS_OE(ws_oe), .SCK_I(sck_p), .SCK_O(sck_o), .SCK_OE(sck_oe), .SD_O(sd_o),
        .CONTROL_OUT_ZERO_PIN(p0), .CONTROL_OUT_TWO_PIN(p2));
    aof_sink_model u_sink (.clk(clk), .arst_n(arst_n), .ext(ext), .run(run), .sck(sck_p), .ws(ws_p),
        .sd(sd_o), .sck_m(sck_m), .ws_m(ws_m), .cap(cap), .n_hi(n_hi), .n_lo(n_lo));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        v = rdata;
    endtask
    // link frame: word select low for one bit only, eight bits a frame
    task automatic send(input logic [7:0] p);
        for (int b = 0; b < 8; b++)
        begin
            @(posedge clk);
            lsd <= p[7 - b];
            lws <= (b != 0);
            lsck <= 1'b0;
            repeat (8) @(posedge clk);
            lsck <= 1'b1;
            repeat (7) @(posedge clk);
        end
    endtask
    task automatic rises(output int n);
        logic q;
        n = 0;
        q = p0;
        repeat (120)
        begin
            cyc(1);
            c2 <= !c2;
            n += int'(p0 && !q);
            q = p0;
        end
    endtask
    task automatic t_regs();
        logic [7:0] al [5] = '{ADDR_AUDIO_MODE, ADDR_MCLK_CTRL, ADDR_MCLK_ROUTE, ADDR_UNDERFLOW_CTRL, ADDR_POLARITY};
        foreach (al[i])
        begin
            rd(al[i]);
            chk("reset value", 16'h0000, 16'(v));
        end
        wr(ADDR_MCLK_CTRL, 8'h5a);
        wr(8'h40, 8'hff);
        rd(8'h40);
        chk("unmapped read", 16'h0000, 16'(v));
        rd(ADDR_MCLK_CTRL);
        chk("readback", 16'h005a, 16'(v));
        wr(ADDR_MCLK_CTRL, 8'h00);
        $display("regs done");
    endtask
    task automatic t_mclk();
        int n;
        wr(ADDR_MCLK_ROUTE, 8'h01);
        wr(ADDR_MCLK_CTRL, 8'h84);
        rises(n);
        chk("osc rate", 16'h1, 16'(n >= 29 && n <= 31));
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_POLARITY, {3'h0, i[1], 4'h0});
            bus32 <= i[0];
            pix <= 4'h1 << i;
            wr(ADDR_MCLK_CTRL, 8'h03);
            rises(n);
            chk("pix rate", 16'h1, 16'(n >= 39 && n <= 41));
            pix <= 4'h1 << ((i + 1) % 4);
            rises(n);
            chk("pix other", 16'h1, 16'(n <= 1));
        end
        wr(ADDR_MCLK_ROUTE, 8'h03);
        cyc(2);
        chk("ws route", 16'(ws_o), 16'(p0));
        wr(ADDR_POLARITY, 8'h00);
        bus32 <= 1'b0;
        wr(ADDR_MCLK_CTRL, 8'h00);
        c0 <= 1'b1;
        cyc(3);
        chk("pin restored", 16'h1, 16'(p0));
        $display("mclk done");
    endtask
    task automatic t_stream();
        logic ok;
        int d;
        repeat (3) send(PAT);
        d = int'(n_lo) - int'(n_hi);
        repeat (3) send(PAT);
        ok = 1'b0;
        for (int k = 0; k < 8; k++)
            ok |= (8'({cap[7:0], cap[7:0]} >> k) == PAT);
        chk("replay", 16'h1, 16'(ok));
        d += int'(n_hi) - int'(n_lo);
        chk("duty", 16'h1, 16'(d >= -8 && d <= 8));
        cyc(400);
        rd(ADDR_UNDERFLOW_STAT);
        chk("unf flag", 16'h1, 16'(v[BIT_FLAG]));
        chk("repeat", 16'h00ff, 16'(cap[7:0]));
        wr(ADDR_UNDERFLOW_CTRL, 8'h04);
        cyc(400);
        chk("zero fill", 16'h0000, 16'(cap[7:0]));
        $display("replay done");
    endtask
    task automatic t_ext();
        logic ok;
        wr(ADDR_AUDIO_MODE, 8'h20);
        ext <= 1'b1;
        cyc(3);
        chk("clock release", 16'h0, 16'(ws_oe));
        rd(ADDR_OVERFLOW_STAT);
        send(PAT);
        send(8'h00);
        rd(ADDR_OVERFLOW_STAT);
        chk("ovf flag", 16'h1, 16'(v[BIT_FLAG]));
        rd(ADDR_OVERFLOW_STAT);
        chk("ovf clear", 16'h0, 16'(v[BIT_FLAG]));
        run <= 1'b1;
        cyc(384);
        run <= 1'b0;
        ok = 1'b0;
        for (int k = 0; k <= 8; k++)
            ok |= (8'(cap >> k) == PAT);
        chk("kept bits", 16'h1, 16'(ok));
        $display("ext done");
    endtask
    initial
    begin
        {arst_n, we, re, lws, lsck, lsd, bus32, c0, c2, ext, run} = '0;
        {addr, wdata, pix} = '0;
        osc = 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_mclk();
        t_stream();
        t_ext();
        finish_test();
    end
endmodule

// ==== core/aof_audio_out.sv ====
// audio output back end: capture, FIFO, serial replay, flags, master clock
//
// Functional notes
// RQ1: frame of 8 to 256 bit clocks measured and replayed.
// RQ2: frame starts at word select fall; low 1 to 255 bit clocks.
// RQ3: one bit clock per data bit, sampled on rising edge.
// RQ4: bits carried as they come, no meaning given.
// RQ5: word select and bit clock polarity programmable both sides.
// RQ6: output keeps input timing; output word select has 50% duty.
// RQ7: output clocks driven by the device or taken from the sink.
// RQ8: with sink clocks, overflow and underflow flags readable.
// RQ9: pin select bit picks the control pin carrying master clock.
// RQ10: master clock off at reset; nonzero divider enables, zero disables.
// RQ11: master clock is source frequency over divider 1 to 127.
// RQ12: software keeps master clock at or below 60 MHz.
// RQ13: source bit low: pixel clock x3/x4, or x6/x8 at low rate.
// RQ14: word-select route sends word select undivided if divider nonzero.
// RQ15: pixel-derived master clock ignores local spread spectrum.
// RQ16: default output timing from measured input rate and oscillator.
// RQ17: external clock mode makes clocks inputs; FIFO absorbs rate.
// RQ18: on overflow incoming bits dropped, buffered data kept.
// RQ19: on underflow last bit repeats, or zeros with zero fill.
// RQ20: overflow and underflow recorded in two status registers.
// RQ21: link stream decoded into the FIFO; channel on after reset.
// RQ22: audio bit clock may be asynchronous to the pixel output clock.
`timescale 1ns/1ns
module aof_audio_out
    import aof_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [7:0] REG_RDATA,
    input wire logic LINK_WS,
    input wire logic LINK_SCK,
    input wire logic LINK_SD,
    input wire logic BUS_WIDTH_32,
    input wire logic [3:0] PIX_MULT_TICK,
    input wire logic OSC_TICK,
    input wire logic CONTROL_OUT_ZERO_IN,
    input wire logic CONTROL_OUT_TWO_IN,
    input wire logic WS_I,
    output logic WS_O,
    output logic WS_OE,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    output logic SD_O,
    output logic CONTROL_OUT_ZERO_PIN,
    output logic CONTROL_OUT_TWO_PIN
);
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // registers
    logic [7:0] audio_mode, mclk_ctrl, mclk_route, uflow_ctrl, polarity;
    logic [7:0] next_audio_mode, next_mclk_ctrl, next_mclk_route, next_uflow_ctrl, next_polarity;
    logic overflow_flag, underflow_flag, next_overflow_flag, next_underflow_flag;
    logic [7:0] next_rdata;
    logic overflow_evt, underflow_evt;

    logic external_audio_clock_mode, underflow_zero_fill, low_rate_select, mclk_pin_select;
    logic mclk_from_word_select, mclk_source_select;
    logic [6:0] mclk_divider;
    assign external_audio_clock_mode = audio_mode[BIT_EXT_CLOCK];
    assign underflow_zero_fill = uflow_ctrl[BIT_ZERO_FILL];
    assign low_rate_select = polarity[BIT_LOW_RATE];
    assign mclk_pin_select = mclk_route[BIT_MCLK_PIN];
    assign mclk_from_word_select = mclk_route[BIT_MCLK_WS];
    assign mclk_source_select = mclk_ctrl[BIT_MCLK_SRC];
    assign mclk_divider = mclk_ctrl[6:0];

    always_comb
    begin
        next_audio_mode = audio_mode;
        next_mclk_ctrl = mclk_ctrl;
        next_mclk_route = mclk_route;
        next_uflow_ctrl = uflow_ctrl;
        next_polarity = polarity;
        next_rdata = 8'h00;
        next_overflow_flag = overflow_flag;
        next_underflow_flag = underflow_flag;
        if (REG_WE)
        begin
            if (reg_hit(REG_ADDR, ADDR_AUDIO_MODE)) next_audio_mode = REG_WDATA; // see RQ17
            if (reg_hit(REG_ADDR, ADDR_MCLK_CTRL)) next_mclk_ctrl = REG_WDATA; // see RQ10
            if (reg_hit(REG_ADDR, ADDR_MCLK_ROUTE)) next_mclk_route = REG_WDATA;
            if (reg_hit(REG_ADDR, ADDR_UNDERFLOW_CTRL)) next_uflow_ctrl = REG_WDATA;
            if (reg_hit(REG_ADDR, ADDR_POLARITY)) next_polarity = REG_WDATA; // see RQ5
        end
        if (REG_RE)
        begin
            case (REG_ADDR)
                ADDR_AUDIO_MODE: next_rdata = audio_mode;
                ADDR_MCLK_CTRL: next_rdata = mclk_ctrl;
                ADDR_MCLK_ROUTE: next_rdata = mclk_route;
                ADDR_UNDERFLOW_CTRL: next_rdata = uflow_ctrl;
                ADDR_POLARITY: next_rdata = polarity;
                ADDR_OVERFLOW_STAT:
                begin
                    next_rdata[BIT_FLAG] = overflow_flag; // see RQ8
                    next_overflow_flag = 1'b0;
                end
                ADDR_UNDERFLOW_STAT:
                begin
                    next_rdata[BIT_FLAG] = underflow_flag; // see RQ8
                    next_underflow_flag = 1'b0;
                end
                default: next_rdata = 8'h00;
            endcase
        end
        // a new event wins over a read clear in the same cycle
        if (overflow_evt) next_overflow_flag = 1'b1; // see RQ20
        if (underflow_evt) next_underflow_flag = 1'b1; // see RQ20
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            audio_mode <= RST_AUDIO_MODE;
            mclk_ctrl <= RST_MCLK_CTRL;
            mclk_route <= RST_MCLK_ROUTE;
            uflow_ctrl <= RST_UNDERFLOW_CTRL;
            polarity <= RST_POLARITY;
            REG_RDATA <= 8'h00;
            overflow_flag <= 1'b0;
            underflow_flag <= 1'b0;
        end
        else
        begin
            audio_mode <= next_audio_mode;
            mclk_ctrl <= next_mclk_ctrl;
            mclk_route <= next_mclk_route;
            uflow_ctrl <= next_uflow_ctrl;
            polarity <= next_polarity;
            REG_RDATA <= next_rdata;
            overflow_flag <= next_overflow_flag;
            underflow_flag <= next_underflow_flag;
        end
    end

    // synchronisers
    // link audio and sink clocks are asynchronous to CLK_SYS
    aof_serial_t link_s1, link_s2, link_s3, ext_s1, ext_s2, ext_s3;
    logic bw32_s1, bw32_s2;
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            link_s1 <= '0;
            link_s2 <= '0;
            link_s3 <= '0;
            ext_s1 <= '0;
            ext_s2 <= '0;
            ext_s3 <= '0;
            bw32_s1 <= 1'b0;
            bw32_s2 <= 1'b0;
        end
        else
        begin
            link_s1 <= '{ws: LINK_WS, sck: LINK_SCK, sd: LINK_SD}; // see RQ22
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            ext_s1 <= '{ws: WS_I, sck: SCK_I, sd: 1'b0};
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            bw32_s1 <= BUS_WIDTH_32;
            bw32_s2 <= bw32_s1;
        end
    end

    // input capture
    logic in_sck_rise, in_ws_now, in_ws_prev, in_frame_start;
    logic [PERIOD_W-1:0] in_cyc_cnt, sck_period, next_in_cyc_cnt, next_sck_period;
    logic [8:0] in_bit_cnt, frame_len, next_in_bit_cnt, next_frame_len;
    logic ws_seen_high, next_ws_seen_high;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    aof_bit_t fifo_in, fifo_out;

    always_comb
    begin
        in_sck_rise = (link_s2.sck ^ polarity[BIT_POL_IN_SCK]) && !(link_s3.sck ^ polarity[BIT_POL_IN_SCK]); // see RQ5
        in_ws_now = link_s2.ws ^ polarity[BIT_POL_IN_WS];
        in_ws_prev = ws_seen_high;
        in_frame_start = in_sck_rise && in_ws_prev && !in_ws_now; // see RQ2
        fifo_in = '{frame_start: in_frame_start, data: link_s2.sd}; // see RQ4
        next_ws_seen_high = in_sck_rise ? in_ws_now : ws_seen_high;
        next_in_cyc_cnt = in_cyc_cnt + 1'b1;
        next_sck_period = sck_period;
        next_in_bit_cnt = in_bit_cnt;
        next_frame_len = frame_len;
        if (in_sck_rise)
        begin
            next_in_cyc_cnt = '0;
            next_sck_period = in_cyc_cnt + 1'b1; // see RQ16
            next_in_bit_cnt = in_bit_cnt + 1'b1;
            if (in_frame_start)
            begin
                next_in_bit_cnt = 9'h001;
                if (in_bit_cnt >= 9'(WS_PERIOD_MIN) && in_bit_cnt <= 9'(WS_PERIOD_MAX))
                begin
                    next_frame_len = in_bit_cnt; // see RQ1
                end
            end
        end
        overflow_evt = in_sck_rise && !fifo_in_ready; // see RQ18
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            in_cyc_cnt <= '0;
            sck_period <= RST_SCK_PERIOD;
            in_bit_cnt <= '0;
            frame_len <= 9'(WS_PERIOD_MAX);
            ws_seen_high <= 1'b0;
        end
        else
        begin
            in_cyc_cnt <= next_in_cyc_cnt;
            sck_period <= next_sck_period;
            in_bit_cnt <= next_in_bit_cnt;
            frame_len <= next_frame_len;
            ws_seen_high <= next_ws_seen_high;
        end
    end

    // a full FIFO refuses the push: new bit lost, buffer kept
    aof_fifo #(
        .WIDTH($bits(aof_bit_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .in_valid(in_sck_rise), // see RQ21
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    // output engine
    logic [PERIOD_W-1:0] half_cnt, next_half_cnt;
    logic gen_sck, next_gen_sck;
    logic [8:0] out_bit_idx, next_out_bit_idx;
    logic out_ws, next_out_ws, out_sd, next_out_sd, last_bit, next_last_bit;
    logic shift_evt, gen_fall, ext_fall;
    logic [PERIOD_W-1:0] half_period;

    always_comb
    begin
        half_period = (sck_period >> 1) == '0 ? PERIOD_W'(1) : (sck_period >> 1);
        next_half_cnt = half_cnt + 1'b1;
        next_gen_sck = gen_sck;
        gen_fall = 1'b0;
        if (half_cnt + 1'b1 >= half_period)
        begin
            next_half_cnt = '0;
            next_gen_sck = !gen_sck;
            gen_fall = gen_sck;
        end
        ext_fall = !(ext_s2.sck ^ polarity[BIT_POL_OUT_SCK]) && (ext_s3.sck ^ polarity[BIT_POL_OUT_SCK]);
        // data moves on the fall so the sink samples it on the rise
        shift_evt = external_audio_clock_mode ? ext_fall : gen_fall; // see RQ3
        fifo_pop = shift_evt && fifo_out_valid;
        underflow_evt = shift_evt && !fifo_out_valid;
        next_out_bit_idx = out_bit_idx;
        next_out_sd = out_sd;
        next_last_bit = last_bit;
        next_out_ws = out_ws;
        if (shift_evt)
        begin
            if (fifo_out_valid)
            begin
                next_out_sd = fifo_out.data;
                next_last_bit = fifo_out.data;
                next_out_bit_idx = (fifo_out.frame_start || out_bit_idx + 1'b1 >= frame_len) ? '0 : out_bit_idx + 1'b1;
            end
            else
            begin
                next_out_sd = underflow_zero_fill ? 1'b0 : last_bit; // see RQ19
                next_out_bit_idx = (out_bit_idx + 1'b1 >= frame_len) ? '0 : out_bit_idx + 1'b1;
            end
            next_out_ws = next_out_bit_idx >= (frame_len >> 1); // see RQ6
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            half_cnt <= '0;
            gen_sck <= 1'b0;
            out_bit_idx <= '0;
            out_ws <= 1'b1;
            out_sd <= 1'b0;
            last_bit <= 1'b0;
        end
        else
        begin
            half_cnt <= next_half_cnt;
            gen_sck <= next_gen_sck;
            out_bit_idx <= next_out_bit_idx;
            out_ws <= next_out_ws;
            out_sd <= next_out_sd;
            last_bit <= next_last_bit;
        end
    end

    // master clock
    aof_msrc_t msrc;
    logic src_tick, mclk, next_mclk, next_ws_o, next_sck_o, next_oe;
    logic [6:0] mclk_cnt, next_mclk_cnt;
    logic next_ctl0, next_ctl2, mclk_on, mclk_bit;

    always_comb
    begin
        // pixel ticks come from the spread-free path
        if (mclk_source_select) msrc = MSRC_OSC;
        else if (bw32_s2) msrc = MSRC_PIX_X4;
        else msrc = MSRC_PIX_X3; // see RQ15
        case (msrc)
            MSRC_PIX_X3: src_tick = low_rate_select ? PIX_MULT_TICK[2] : PIX_MULT_TICK[0]; // see RQ13
            MSRC_PIX_X4: src_tick = low_rate_select ? PIX_MULT_TICK[3] : PIX_MULT_TICK[1]; // see RQ13
            MSRC_OSC: src_tick = OSC_TICK;
            default: src_tick = 1'b0;
        endcase
        mclk_on = mclk_divider != 7'h00; // see RQ10
        next_mclk_cnt = mclk_cnt;
        next_mclk = mclk;
        if (!mclk_on)
        begin
            next_mclk_cnt = '0;
            next_mclk = 1'b0;
        end
        else if (mclk_divider == 7'h01)
        begin
            next_mclk = src_tick;
        end
        else if (src_tick)
        begin
            // one period per divider source ticks
            next_mclk_cnt = (mclk_cnt + 1'b1 >= mclk_divider) ? '0 : mclk_cnt + 1'b1; // see RQ11
            next_mclk = next_mclk_cnt < (mclk_divider >> 1);
        end
        mclk_bit = mclk_from_word_select ? next_out_ws : next_mclk; // see RQ14
        next_ctl0 = CONTROL_OUT_ZERO_IN;
        next_ctl2 = CONTROL_OUT_TWO_IN;
        if (mclk_on && mclk_pin_select) next_ctl0 = mclk_bit; // see RQ9
        if (mclk_on && !mclk_pin_select) next_ctl2 = mclk_bit; // see RQ9
        next_oe = !external_audio_clock_mode; // see RQ7
        next_ws_o = next_out_ws ^ polarity[BIT_POL_OUT_WS];
        next_sck_o = next_gen_sck ^ polarity[BIT_POL_OUT_SCK];
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mclk_cnt <= '0;
            mclk <= 1'b0;
            CONTROL_OUT_ZERO_PIN <= 1'b0;
            CONTROL_OUT_TWO_PIN <= 1'b0;
            WS_O <= 1'b0;
            SCK_O <= 1'b0;
            WS_OE <= 1'b0;
            SCK_OE <= 1'b0;
            SD_O <= 1'b0;
        end
        else
        begin
            mclk_cnt <= next_mclk_cnt;
            mclk <= next_mclk;
            CONTROL_OUT_ZERO_PIN <= next_ctl0;
            CONTROL_OUT_TWO_PIN <= next_ctl2;
            WS_O <= next_ws_o;
            SCK_O <= next_sck_o;
            WS_OE <= next_oe; // see RQ17
            SCK_OE <= next_oe; // see RQ17
            SD_O <= next_out_sd;
        end
    end
endmodule

// ==== core/aof_fifo.sv ====
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module aof_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic do_push, do_pop;

    always_comb
    begin
        do_push = in_valid && in_ready;
        do_pop = out_valid && out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (do_push)
        begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage needs no reset; only pointers and count define what is valid
    always_ff @(posedge clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
endmodule

// ==== core/aof_pkg.sv ====
// package: register map, fields and types of the audio output block
package aof_pkg;
    localparam logic [7:0] ADDR_AUDIO_MODE = 8'h02;
    localparam logic [7:0] ADDR_MCLK_CTRL = 8'h12;
    localparam logic [7:0] ADDR_MCLK_ROUTE = 8'h15;
    localparam logic [7:0] ADDR_UNDERFLOW_CTRL = 8'h1d;
    localparam logic [7:0] ADDR_POLARITY = 8'h1e;
    localparam logic [7:0] ADDR_OVERFLOW_STAT = 8'h78;
    localparam logic [7:0] ADDR_UNDERFLOW_STAT = 8'h79;

    localparam int BIT_EXT_CLOCK = 5;
    localparam int BIT_MCLK_SRC = 7;
    localparam int BIT_MCLK_WS = 1;
    localparam int BIT_MCLK_PIN = 0;
    localparam int BIT_ZERO_FILL = 2;
    localparam int BIT_POL_IN_WS = 0;
    localparam int BIT_POL_IN_SCK = 1;
    localparam int BIT_POL_OUT_WS = 2;
    localparam int BIT_POL_OUT_SCK = 3;
    localparam int BIT_LOW_RATE = 4;
    localparam int BIT_FLAG = 0;

    localparam logic [7:0] RST_AUDIO_MODE = 8'h00;
    localparam logic [7:0] RST_MCLK_CTRL = 8'h00;
    localparam logic [7:0] RST_MCLK_ROUTE = 8'h00;
    localparam logic [7:0] RST_UNDERFLOW_CTRL = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'h00;

    localparam int WS_PERIOD_MIN = 8;
    localparam int WS_PERIOD_MAX = 256;
    localparam int WS_LOW_MAX = 255;
    localparam int FIFO_DEPTH = 8;
    localparam int PERIOD_W = 16;
    localparam logic [PERIOD_W-1:0] RST_SCK_PERIOD = 16'h0010;

    typedef struct packed {
        logic frame_start;
        logic data;
    } aof_bit_t;

    typedef struct packed {
        logic ws;
        logic sck;
        logic sd;
    } aof_serial_t;

    typedef enum logic [2:0] {
        MSRC_PIX_X3 = 3'h1,
        MSRC_PIX_X4 = 3'h2,
        MSRC_OSC = 3'h4
    } aof_msrc_t;
endpackage
